/* File: hw/spr_cvt_if.sv */
`timescale 1ns/1ns
`default_nettype none
// start and result handshake between sequencer and approximation engine
interface spr_cvt_if;
  logic                      start;
  logic [spr_pkg::RES_W-1:0] level;
  logic                      done;
  logic [spr_pkg::RES_W-1:0] code;

  modport ctl (output start, output level, input done, input code);
  modport sar (input start, input level, output done, output code);
endinterface
`default_nettype wire

/* File: hw/spr_pkg.sv */
// shared constants and types for the converter control and readout block
package spr_pkg;

  // result geometry
  localparam int RES_W      = 14;
  localparam int BYTE_W     = 8;
  localparam int UPPER_W    = RES_W - BYTE_W;
  localparam int PAD_W      = BYTE_W - UPPER_W;
  localparam int BIT_IDX_W  = 4;
  localparam logic [BIT_IDX_W-1:0] TOP_BIT = 4'hd;
  localparam logic [BIT_IDX_W-1:0] IDX_ONE = 4'h1;
  localparam logic [BIT_IDX_W-1:0] IDX_ZERO = 4'h0;

  // core clock rate
  localparam int CLK_PERIOD_NS = 100;

  // longest conversion time, rounded down to whole cycles
  localparam int T_CONV_MAX_NS = 4700;
  localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / CLK_PERIOD_NS;

  // successive-approximation step rate, one enable every few cycles
  localparam int STEP_DIV_W = 2;
  localparam logic [STEP_DIV_W-1:0] STEP_LAST = 2'h2;
  localparam logic [STEP_DIV_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [STEP_DIV_W-1:0] STEP_ONE  = 2'h1;

  // reference wake-up and settling time, rounded up to whole cycles
  localparam int T_REF_SETTLE_US = 12000;
  localparam int REF_SETTLE_CYC  = (T_REF_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W        = 17;

  // zero, one and first-trial values
  localparam logic [RES_W-1:0]  RES_ZERO  = 14'h0000;
  localparam logic [RES_W-1:0]  MSB_TRIAL = 14'h2000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [PAD_W-1:0]  PAD_ZERO  = 2'h0;
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 17'h00000;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE  = 17'h00001;

  // sequencing states, one-hot
  typedef enum logic [4:0] {
    SPR_OFF  = 5'h01,
    SPR_ACQ  = 5'h02,
    SPR_CONV = 5'h04,
    SPR_DONE = 5'h08,
    SPR_READ = 5'h10
  } spr_state_t;

endpackage

/* File: hw/spr_sar.sv */
`timescale 1ns/1ns
`default_nettype none
// successive-approximation engine run from a divided internal step enable
module spr_sar (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  spr_cvt_if.sar    cvt
);

  typedef struct packed {
    logic                                busy;
    logic [spr_pkg::RES_W-1:0]           hold;
    logic [spr_pkg::RES_W-1:0]           trial;
    logic [spr_pkg::BIT_IDX_W-1:0]       idx;
    logic [spr_pkg::STEP_DIV_W-1:0]      div;
    logic                                done;
  } spr_sar_st_t;

  spr_sar_st_t q;
  spr_sar_st_t next_q;

  // one bit decided per step; the held level stands still meanwhile
  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    if (cvt.start) begin
      next_q.busy  = 1'b1;
      next_q.hold  = cvt.level;
      next_q.trial = spr_pkg::MSB_TRIAL;
      next_q.idx   = spr_pkg::TOP_BIT;
      next_q.div   = spr_pkg::STEP_ZERO;
    end else if (q.busy) begin
      next_q.div = q.div + spr_pkg::STEP_ONE;
      if (q.div == spr_pkg::STEP_LAST) begin
        next_q.div = spr_pkg::STEP_ZERO;
        if (q.trial > q.hold) begin
          next_q.trial[q.idx] = 1'b0;
        end
        if (q.idx == spr_pkg::IDX_ZERO) begin
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
        end else begin
          next_q.idx                        = q.idx - spr_pkg::IDX_ONE;
          next_q.trial[q.idx - spr_pkg::IDX_ONE] = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign cvt.done = q.done;
  assign cvt.code = q.trial;

  // fixed conversion length from start to done
  AST_SAR_LENGTH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cvt.start |-> ##43 cvt.done)
    else $error("conversion engine did not finish in 43 cycles");

  // finished code equals the held level
  AST_SAR_CODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cvt.done |-> cvt.code == q.hold)
    else $error("conversion code differs from held level");

endmodule
`default_nettype wire

/* File: hw/spr_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - end-of-conversion flag falls when conversion finishes
// - fourteen result bits on three-state outputs
// - outputs released during acquisition and conversion
// - third strobe fall with select high drives result
// - strobe rising after read releases outputs
// - idle afterwards until next strobe fall
// - upper-byte select picks low or high byte
// - two top bits of upper byte zero
// - offset binary bipolar, straight binary unipolar
// - select at second fall: shutdown or standby
// - first fall with select low starts acquisition
// - second fall converts; flag within conversion time
module spr_top #(
  parameter int REF_SETTLE_CYC = spr_pkg::REF_SETTLE_CYC
) (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        CONV_START_N_I,
  input  wire logic                        READ_SEL_I,
  input  wire logic                        UPPER_BYTE_SELECT_I,
  input  wire logic                        RANGE_BIPOLAR_I,
  input  wire logic [spr_pkg::RES_W-1:0]   AIN_LEVEL_I,
  output var  logic [spr_pkg::BYTE_W-1:0]  RESULT_BITS_O,
  output var  logic                        RESULT_BITS_OE_O,
  output var  logic                        EOC_N_O,
  output var  logic                        CORE_ON_O,
  output var  logic                        REF_ON_O,
  output var  logic                        REF_READY_O
);

  typedef struct packed {
    spr_pkg::spr_state_t                 state;
    logic                                cs_prev;
    logic                                shut_sel;
    logic                                core_on;
    logic                                ref_on;
    logic                                ref_ready;
    logic [spr_pkg::SETTLE_W-1:0]        settle_cnt;
    logic                                eoc_n;
    logic                                oe;
    logic [spr_pkg::BYTE_W-1:0]          dbus;
    logic [spr_pkg::RES_W-1:0]           result;
    logic                                start;
  } spr_top_st_t;

  spr_top_st_t q;
  spr_top_st_t next_q;
  logic        cs_fall;

  spr_cvt_if cvt ();

  // byte steering for the eight-bit output bus
  function automatic logic [spr_pkg::BYTE_W-1:0] pick_byte(
    input logic [spr_pkg::RES_W-1:0] res,
    input logic                      upper
  );
    logic [spr_pkg::BYTE_W-1:0] b;
    if (upper) begin
      b = {spr_pkg::PAD_ZERO, res[spr_pkg::RES_W-1:spr_pkg::BYTE_W]};
    end else begin
      b = res[spr_pkg::BYTE_W-1:0];
    end
    return b;
  endfunction

  // input scaler: bipolar levels arrive two's complement, shifted to offset
  function automatic logic [spr_pkg::RES_W-1:0] scale_level(
    input logic [spr_pkg::RES_W-1:0] lvl,
    input logic                      bipolar
  );
    logic [spr_pkg::RES_W-1:0] s;
    s = lvl;
    if (bipolar) begin
      s[spr_pkg::RES_W-1] = ~lvl[spr_pkg::RES_W-1];
    end
    return s;
  endfunction

  // strobe edges; pins are synchronous to the core clock
  assign cs_fall   = q.cs_prev & ~CONV_START_N_I;
  // the engine latches the level on start, so a live feed is enough
  assign cvt.start = q.start;
  assign cvt.level = scale_level(AIN_LEVEL_I, RANGE_BIPOLAR_I);

  spr_sar u_sar (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .cvt     (cvt.sar)
  );

  // sequencer and output bus
  always_comb begin
    next_q         = q;
    next_q.start   = 1'b0;
    next_q.cs_prev = CONV_START_N_I;
    case (q.state)
      spr_pkg::SPR_OFF: begin
        if (cs_fall && !READ_SEL_I) begin
          next_q.state   = spr_pkg::SPR_ACQ;
          next_q.core_on = 1'b1;
          next_q.ref_on  = 1'b1;
          next_q.eoc_n   = 1'b1;
        end
      end
      spr_pkg::SPR_ACQ: begin
        if (cs_fall) begin
          next_q.state    = spr_pkg::SPR_CONV;
          next_q.start    = 1'b1;
          next_q.shut_sel = READ_SEL_I;
        end
      end
      spr_pkg::SPR_CONV: begin
        if (cvt.done) begin
          next_q.state   = spr_pkg::SPR_DONE;
          next_q.result  = cvt.code;
          next_q.core_on = 1'b0;
          next_q.eoc_n   = 1'b0;
          if (q.shut_sel) begin
            next_q.ref_on    = 1'b0;
            next_q.ref_ready = 1'b0;
          end
        end
      end
      spr_pkg::SPR_DONE: begin
        if (cs_fall && READ_SEL_I) begin
          next_q.state = spr_pkg::SPR_READ;
          next_q.oe    = 1'b1;
          next_q.dbus  = pick_byte(q.result, UPPER_BYTE_SELECT_I);
        end
      end
      spr_pkg::SPR_READ: begin
        // byte may change while strobe stays low
        next_q.dbus = pick_byte(q.result, UPPER_BYTE_SELECT_I);
        if (CONV_START_N_I) begin
          next_q.state = spr_pkg::SPR_OFF;
          next_q.oe    = 1'b0;
          next_q.dbus  = spr_pkg::BYTE_ZERO;
        end
      end
      default: begin
        next_q.state = spr_pkg::SPR_OFF;
        next_q.oe    = 1'b0;
        next_q.dbus  = spr_pkg::BYTE_ZERO;
      end
    endcase
    // reference settling status, only a hint: the host must time the wait
    if (q.ref_on && !q.ref_ready && next_q.ref_on) begin
      next_q.settle_cnt = q.settle_cnt + spr_pkg::SETTLE_ONE;
      if (q.settle_cnt == spr_pkg::SETTLE_W'(REF_SETTLE_CYC - 1)) begin
        next_q.ref_ready = 1'b1;
      end
    end else if (!next_q.ref_on) begin
      next_q.settle_cnt = spr_pkg::SETTLE_ZERO;
    end
  end

  // state register; strobe idles high so its history resets high
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q         <= '0;
      q.state   <= spr_pkg::SPR_OFF;
      q.cs_prev <= 1'b1;
      q.eoc_n   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  // byte, enable, flag and power pins
  assign RESULT_BITS_O    = q.dbus;
  assign RESULT_BITS_OE_O = q.oe;
  assign EOC_N_O          = q.eoc_n;
  assign CORE_ON_O        = q.core_on;
  assign REF_ON_O         = q.ref_on;
  assign REF_READY_O      = q.ref_ready;

  localparam int AST_CONV_LIM = spr_pkg::CONV_MAX_CYC;

  default clocking ast_cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // flag falls with the done state
  AST_EOC_FALLS: assert property (
    q.state == spr_pkg::SPR_CONV && cvt.done |=> !EOC_N_O && $rose(q.state[3]))
    else $error("flag did not fall with conversion end");

  // flag holds low while the result waits
  AST_EOC_HOLDS: assert property (
    q.state == spr_pkg::SPR_DONE || q.state == spr_pkg::SPR_READ |-> !EOC_N_O)
    else $error("flag rose before the result was read");

  // no drive while sampling or converting
  AST_HIZ_BUSY: assert property (
    q.state == spr_pkg::SPR_ACQ || q.state == spr_pkg::SPR_CONV |-> !RESULT_BITS_OE_O)
    else $error("bus driven during acquisition or conversion");

  // read fall loads the selected byte
  AST_READ_DRIVES: assert property (
    q.state == spr_pkg::SPR_DONE && cs_fall && READ_SEL_I
    |=> RESULT_BITS_OE_O && RESULT_BITS_O == pick_byte(q.result, $past(UPPER_BYTE_SELECT_I)))
    else $error("third strobe fall did not drive result");

  // read fall with select low leaves the bus released
  AST_READ_REFUSED: assert property (
    q.state == spr_pkg::SPR_DONE && cs_fall && !READ_SEL_I
    |=> q.state == spr_pkg::SPR_DONE && !RESULT_BITS_OE_O)
    else $error("read fall with select low was taken");

  // strobe high releases the bus
  AST_RELEASE: assert property (
    q.state == spr_pkg::SPR_READ && CONV_START_N_I |=> !RESULT_BITS_OE_O)
    else $error("bus not released after strobe high");

  // a released bus never shows a stale byte
  AST_BUS_IDLE_ZERO: assert property (
    !RESULT_BITS_OE_O |-> RESULT_BITS_O == spr_pkg::BYTE_ZERO)
    else $error("released bus shows a stale byte");

  // idle holds until a strobe fall
  AST_IDLE_WAIT: assert property (
    q.state == spr_pkg::SPR_OFF && !cs_fall |=> q.state == spr_pkg::SPR_OFF)
    else $error("left idle without strobe fall");

  // low byte while select is low
  AST_BYTE_SELECT: assert property (
    q.state == spr_pkg::SPR_READ && !CONV_START_N_I && !UPPER_BYTE_SELECT_I
    |=> RESULT_BITS_O == q.result[spr_pkg::BYTE_W-1:0])
    else $error("low byte not presented");

  // upper byte while select is high
  AST_UPPER_BYTE: assert property (
    q.state == spr_pkg::SPR_READ && !CONV_START_N_I && UPPER_BYTE_SELECT_I
    |=> RESULT_BITS_O == {spr_pkg::PAD_ZERO, q.result[spr_pkg::RES_W-1:spr_pkg::BYTE_W]})
    else $error("upper byte not presented");

  // pad bits of the upper byte
  AST_UPPER_PAD: assert property (
    RESULT_BITS_OE_O && $past(UPPER_BYTE_SELECT_I)
    |-> RESULT_BITS_O[spr_pkg::BYTE_W-1:spr_pkg::UPPER_W] == spr_pkg::PAD_ZERO)
    else $error("upper byte pad bits not zero");

  // msb flipped only for bipolar ranges
  AST_CODING: assert property (
    cvt.start |-> (cvt.level[spr_pkg::RES_W-1] != AIN_LEVEL_I[spr_pkg::RES_W-1]) == RANGE_BIPOLAR_I)
    else $error("wrong output coding for input range");

  // latched choice decides the reference
  AST_POWER_MODE: assert property (
    q.state == spr_pkg::SPR_CONV && cvt.done |=> REF_ON_O == !$past(q.shut_sel) && !CORE_ON_O)
    else $error("power-down mode not applied after conversion");

  // settled status only while the reference is on
  AST_READY_NEEDS_REF: assert property (
    REF_READY_O |-> REF_ON_O)
    else $error("reference ready shown while reference off");

  // wake with select high is refused
  AST_WAKE_IGNORED: assert property (
    q.state == spr_pkg::SPR_OFF && cs_fall && READ_SEL_I |=> q.state == spr_pkg::SPR_OFF)
    else $error("wake edge with select high not ignored");

  // wake with select low powers up and acquires
  AST_WAKE_POWERS: assert property (
    q.state == spr_pkg::SPR_OFF && cs_fall && !READ_SEL_I
    |=> q.state == spr_pkg::SPR_ACQ && CORE_ON_O && REF_ON_O && EOC_N_O)
    else $error("wake edge with select low did not power up");

  // engine start only with the core powered
  AST_START_CONVERTS: assert property (
    cvt.start |-> q.state == spr_pkg::SPR_CONV && CORE_ON_O)
    else $error("engine started outside conversion");

  // flag within the longest conversion time
  AST_CONV_TIME: assert property (
    q.state == spr_pkg::SPR_ACQ && cs_fall |-> ##[1:AST_CONV_LIM] !EOC_N_O)
    else $error("conversion exceeded longest time");

  // main scenarios: both power modes, both bytes, refused read
  COV_STANDBY: cover property (
    q.state == spr_pkg::SPR_CONV && cvt.done && !q.shut_sel);
  COV_SHUTDOWN: cover property (
    q.state == spr_pkg::SPR_CONV && cvt.done && q.shut_sel);
  COV_TWO_BYTES: cover property (
    q.state == spr_pkg::SPR_READ && !UPPER_BYTE_SELECT_I ##1
    q.state == spr_pkg::SPR_READ && UPPER_BYTE_SELECT_I);
  COV_REF_READY: cover property ($rose(REF_READY_O));
  COV_READ_REFUSED: cover property (
    q.state == spr_pkg::SPR_DONE && cs_fall && !READ_SEL_I);

endmodule
`default_nettype wire

/* File: tb/sar_adc_parallel_readout_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
// self-checking bench for the converter readout block
module sar_adc_parallel_readout_tb;
  localparam int SETTLE = 20;
  logic                        core_clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        conv_start_n, read_sel, upper_sel, pd;
  logic                        range_bipolar = 1'b0;
  logic [spr_pkg::RES_W-1:0]   ain_level = 14'h0000;
  logic [spr_pkg::RES_W-1:0]   exp_r;
  logic [spr_pkg::RES_W-1:0]   lvls [4] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff};
  logic [spr_pkg::BYTE_W-1:0]  result_bits;
  logic                        oe, eoc_n, core_on, ref_on, ref_ready;
  int                          num_errors = 0;
  int                          num_checks = 0;
  int                          cyc = 0;

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  spr_top #(.REF_SETTLE_CYC(SETTLE)) u_dut (
    .CORE_CLK_I(core_clk), .RST_N_I(rst_n), .CONV_START_N_I(conv_start_n),
    .READ_SEL_I(read_sel), .UPPER_BYTE_SELECT_I(upper_sel),
    .RANGE_BIPOLAR_I(range_bipolar), .AIN_LEVEL_I(ain_level),
    .RESULT_BITS_O(result_bits), .RESULT_BITS_OE_O(oe), .EOC_N_O(eoc_n),
    .CORE_ON_O(core_on), .REF_ON_O(ref_on), .REF_READY_O(ref_ready)
  );

  spr_host #(.SETTLE(SETTLE)) u_host (
    .clk_i(core_clk), .eoc_n_i(eoc_n), .oe_i(oe), .core_on_i(core_on),
    .ref_on_i(ref_on), .ref_ready_i(ref_ready), .bits_i(result_bits),
    .conv_start_n_o(conv_start_n), .read_sel_o(read_sel),
    .upper_byte_select_o(upper_sel)
  );

  // expected code: msb flipped for the bipolar ranges
  function automatic logic [13:0] exp_res(input logic [13:0] l, input logic bip);
    return bip ? (l ^ 14'h2000) : l;
  endfunction

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, far above twelve sequences of under 120 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // corners first, then random levels, ranges and power-down modes
  initial begin
    void'($urandom(32'h35fb));
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    `CHK(oe, 1'b0)
    `CHK(eoc_n, 1'b1)
    for (int i = 0; i < 12; i++) begin
      if (i < 4) begin
        ain_level = lvls[i];
        range_bipolar = i[0];
        pd = i[1];
      end else begin
        {ain_level, range_bipolar, pd} = 16'($urandom());
      end
      exp_r = exp_res(ain_level, range_bipolar);
      u_host.run(pd);
      `CHK(u_host.ign_core, 1'b0)
      `CHK(u_host.woke, 1'b1)
      `CHK(u_host.rdy, 1'b1)
      `CHK(u_host.oe_busy, 1'b0)
      `CHK(u_host.eoc_cyc, 45)
      `CHK(u_host.eoc_cyc <= spr_pkg::CONV_MAX_CYC, 1'b1)
      `CHK(u_host.ref_end, ~pd)
      `CHK(u_host.core_end, 1'b0)
      `CHK(u_host.oe_rd, 1'b1)
      `CHK(u_host.lo, exp_r[7:0])
      `CHK(u_host.hi, {2'h0, exp_r[13:8]})
      `CHK(u_host.oe_rel, 1'b0)
      `CHK(u_host.rel_bits, 8'h00)
      `CHK(u_host.core_rel, 1'b0)
      $display("test %0d done", i);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: tb/spr_host.sv */
`timescale 1ns/1ns
`default_nettype none
// behavioural host on the strobe, select and byte lines
module spr_host #(
  parameter int SETTLE = 20
) (
  input  wire logic       clk_i,
  input  wire logic       eoc_n_i,
  input  wire logic       oe_i,
  input  wire logic       core_on_i,
  input  wire logic       ref_on_i,
  input  wire logic       ref_ready_i,
  input  wire logic [7:0] bits_i,
  output var  logic       conv_start_n_o,
  output var  logic       read_sel_o,
  output var  logic       upper_byte_select_o
);
  logic [7:0] lo, hi, rel_bits;
  logic       ign_core, woke, rdy, oe_busy, oe_rd, oe_rel, core_rel, ref_end, core_end;
  int         eoc_cyc;
  logic       need_settle = 1'b1;

  // strobe idles high from time zero, so no false edge at reset release
  initial begin
    conv_start_n_o = 1'b1;
    read_sel_o = 1'b0;
    upper_byte_select_o = 1'b0;
  end

  // one-cycle low strobe; returns once the answer edge has passed
  task automatic pulse(input logic sel);
    @(negedge clk_i);
    read_sel_o = sel;
    conv_start_n_o = 1'b0;
    @(negedge clk_i);
    conv_start_n_o = 1'b1;
    @(negedge clk_i);
  endtask

  // one full wake, convert and read sequence
  task automatic run(input logic pd);
    pulse(1'b1);
    ign_core = core_on_i;
    pulse(1'b0);
    woke = core_on_i & ref_on_i;
    oe_busy = oe_i;
    if (need_settle) repeat (SETTLE + 2) @(negedge clk_i);
    rdy = ref_ready_i;
    pulse(pd);
    eoc_cyc = 1;
    while (eoc_n_i !== 1'b0 && eoc_cyc < 60) begin
      @(posedge clk_i);
      #1;
      eoc_cyc++;
      oe_busy = oe_busy | oe_i;
    end
    // the low flag is first sampled one edge after its launch
    eoc_cyc++;
    core_end = core_on_i;
    ref_end = ref_on_i;
    need_settle = pd;
    // a read fall with select low must be refused
    pulse(1'b0);
    oe_busy = oe_busy | oe_i;
    @(negedge clk_i);
    read_sel_o = 1'b1;
    upper_byte_select_o = 1'b0;
    conv_start_n_o = 1'b0;
    repeat (2) @(negedge clk_i);
    lo = bits_i;
    oe_rd = oe_i;
    upper_byte_select_o = 1'b1;
    repeat (2) @(negedge clk_i);
    hi = bits_i;
    conv_start_n_o = 1'b1;
    repeat (2) @(negedge clk_i);
    oe_rel = oe_i;
    rel_bits = bits_i;
    core_rel = core_on_i;
    upper_byte_select_o = 1'b0;
  endtask
endmodule
`default_nettype wire
